/* File: core/ifp_pkg.sv */
// Purpose: shared constants and types of the interrupt flag and priority block
// Assumes: 8-bit special function register bus, 14 sources in polling order
// Notes:   source index equals polling position, lower index wins a tie
package ifp_pkg;
  localparam int          N_SRC    = 14;
  localparam int          N_GRP    = 6;
  localparam int          LVL_W    = 2;
  localparam int          SRC_W    = 4;
  localparam int          N_EVT    = 3;
  // register addresses
  localparam logic [7:0]  A_AES    = 8'h98;
  localparam logic [7:0]  A_RADIO  = 8'h9b;
  localparam logic [7:0]  A_PRI_LO = 8'ha9;
  localparam logic [7:0]  A_PRI_HI = 8'hb9;
  localparam logic [7:0]  A_FL4    = 8'hc0;
  localparam logic [7:0]  A_FL5    = 8'he8;
  localparam logic [7:0]  A_EN_LO  = 8'hd1;
  localparam logic [7:0]  A_EN_HI  = 8'hd2;
  localparam logic [7:0]  A_STAT   = 8'hd3;
  localparam logic [7:0]  A_MASK   = 8'hd4;
  localparam logic [7:0]  A_INSVC  = 8'hd5;
  // field positions of the fourth and fifth flag registers
  localparam int          B_DMA    = 0;
  localparam int          B_T1     = 1;
  localparam int          B_T4     = 4;
  localparam int          B_P0     = 5;
  localparam int          B_KEEP0  = 6;
  localparam int          B_ST     = 7;
  localparam int          B_P2     = 0;
  localparam int          B_UTX0   = 1;
  localparam int          B_UTX1   = 2;
  localparam int          B_P1     = 3;
  localparam int          B_WDT    = 4;
  // reset values
  localparam logic [7:0]  RST_REG  = 8'h00;
  // block event status bits
  localparam int          E_VEC    = 0;
  localparam int          E_NEST   = 1;
  localparam int          E_RET    = 2;

  typedef enum logic [3:0] {
    SRC_RADIO = 4'h0, SRC_DMA  = 4'h1, SRC_T1   = 4'h2, SRC_T2  = 4'h3,
    SRC_T3    = 4'h4, SRC_AES  = 4'h5, SRC_T4   = 4'h6, SRC_ST  = 4'h7,
    SRC_P0    = 4'h8, SRC_P2   = 4'h9, SRC_UTX0 = 4'ha, SRC_UTX1 = 4'hb,
    SRC_P1    = 4'hc, SRC_WDT  = 4'hd
  } ifp_src_e;

  // priority group of each source, indexed by polling position
  localparam logic [2:0] GRP_OF [N_SRC] = '{
    3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5
  };

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ifp_bus_s;

  typedef struct packed {
    logic       aes;
    logic       radio;
    logic [3:0] timer;     // timer 4 down to timer 1
    logic       sleep;
    logic       port0;
    logic       dma;
    logic       wdt;
    logic       port1;
    logic       utx1;
    logic       utx0;
    logic       port2;
  } ifp_evt_s;
endpackage

/* File: core/ifp_evt_status.sv */
// Purpose: sticky event status, mask and level interrupt output
// Assumes: write-one-to-clear status, plain read/write mask
// Notes:   a set in the clearing cycle survives
`timescale 1ns/1ns
module ifp_evt_status #(
  parameter int W = 3
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  input  wire logic         mask_wr_in,
  input  wire logic [W-1:0] mask_in,
  output logic      [W-1:0] stat_out,
  output logic      [W-1:0] mask_out,
  output logic              irq_out
);
  generate
    if (W < 1 || W > 8) begin : g_bad
      $error("status width must be 1 to 8");
    end
  endgenerate

  // one sticky bit per event, set beats clear
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          stat_out[i] <= 1'b0;
        end else if (ce_in) begin
          stat_out[i] <= set_in[i] | (stat_out[i] & ~clr_in[i]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_out <= '0;
    end else if (ce_in && mask_wr_in) begin
      mask_out <= mask_in;
    end
  end

  assign irq_out = |(stat_out & mask_out);

  chk_irq_follows_stat: // status
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && set_in[0] && mask_out[0] && !mask_wr_in) |=> irq_out)
    else $error("masked-in event did not raise the interrupt");
endmodule

/* File: core/ifp_prio_arb.sv */
// Purpose: pick the highest-level request, ties by polling position
// Assumes: request index equals polling position
// Notes:   purely combinational, the caller registers the result
`timescale 1ns/1ns
module ifp_prio_arb #(
  parameter int N  = 14,
  parameter int LW = 2,
  parameter int SW = 4
) (
  input  wire logic [N-1:0]    req_in,
  input  wire logic [N*LW-1:0] lvl_in,
  output logic                 vld_out,
  output logic [SW-1:0]        src_out,
  output logic [LW-1:0]        lvl_out
);
  generate
    if (N < 1 || N > (1 << SW)) begin : g_bad
      $error("source count does not fit the index width");
    end
  endgenerate

  // walk downward so that on equal level the lower index is kept last
  always_comb begin
    vld_out = 1'b0;
    src_out = '0;
    lvl_out = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i] && (!vld_out || lvl_in[i*LW +: LW] >= lvl_out)) begin
        vld_out = 1'b1;
        src_out = SW'(i);
        lvl_out = lvl_in[i*LW +: LW];
      end
    end
  end
endmodule

/* File: core/ifp_core.sv */
// Purpose: interrupt pending flags, group priority and request selection
// Assumes: cpu pulses vec_ack_in when it vectors to the presented source
//          and reti_in on return; both only while req_out is high / nested
// Notes:   flag registers are software writable; hardware events win
`timescale 1ns/1ns

// Overview of operation
// - aes has two flag bits 1:0, software setting either requests service
// - an aes event sets both aes flag bits at once
// - radio has two flag bits 1:0, software setting either requests service
// - a radio event sets both radio flag bits at once
// - timer flags bits 1..4 set on event, cleared when cpu vectors
// - fourth register holds sleep timer bit 7, port0 bit 5, dma bit 0
// - fifth register holds watchdog, port1, uart1 tx, uart0 tx, port2; 7:5 unused
// - six priority groups, each set by one bit in each priority register
// - each group gets one of four levels from its two bits
// - a running service is only preempted by a strictly higher level
// - equal-level requests together resolve by fixed polling order
// - high priority register holds group bits 5:0, bits 7:6 read zero
// - low register holds low bit; level is high bit then low bit
// - flags set regardless of enable; enabled flag requested next cycle
module ifp_core (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     ce_in,
  input  wire ifp_pkg::ifp_bus_s        bus_in,
  output logic [7:0]                    rdata_out,
  input  wire ifp_pkg::ifp_evt_s        evt_in,
  input  wire logic                     vec_ack_in,
  input  wire logic                     reti_in,
  output logic                          req_out,
  output logic [ifp_pkg::SRC_W-1:0]     req_src_out,
  output logic [ifp_pkg::LVL_W-1:0]     req_lvl_out,
  output logic                          irq_out
);
  import ifp_pkg::*;

  logic [1:0]             aes_q;
  logic [1:0]             radio_q;
  logic [7:0]             fl4_q;
  logic [4:0]             fl5_q;
  logic [5:0]             pri_hi_q;
  logic [5:0]             pri_lo_q;
  logic [N_SRC-1:0]       en_q;
  logic [3:0]             insvc_q;
  logic [N_SRC-1:0]       pend;
  logic [N_SRC-1:0]       req;
  logic [N_SRC*LVL_W-1:0] lvl;
  logic                   arb_vld;
  logic [SRC_W-1:0]       arb_src;
  logic [LVL_W-1:0]       arb_lvl;
  logic                   svc_any;
  logic [LVL_W-1:0]       svc_lvl;
  logic                   wr;
  logic [3:0]             t_clr;
  logic [N_EVT-1:0]       stat;
  logic [N_EVT-1:0]       mask;
  logic [N_EVT-1:0]       evt_set;
  logic [N_EVT-1:0]       evt_clr;

  assign wr = bus_in.wr;

  // aes flags: software may set or clear, the coprocessor sets both
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aes_q <= RST_REG[1:0];
    end else if (ce_in) begin
      aes_q <= ((wr && bus_in.addr == A_AES) ? bus_in.wdata[1:0] : aes_q)
               | {2{evt_in.aes}};
    end
  end

  // radio flags behave like the aes pair
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      radio_q <= RST_REG[1:0];
    end else if (ce_in) begin
      radio_q <= ((wr && bus_in.addr == A_RADIO) ? bus_in.wdata[1:0] : radio_q)
                 | {2{evt_in.radio}};
    end
  end

  // timer flags drop when the cpu vectors to that timer
  always_comb begin
    t_clr = '0;
    if (vec_ack_in) begin
      for (int t = 0; t < 4; t++) begin
        t_clr[t] = (req_src_out == SRC_T1 + SRC_W'(t)) && (t != 3 || 1'b0);
      end
      t_clr[3] = (req_src_out == SRC_T4); // timer 4 sits out of sequence
      t_clr[2] = (req_src_out == SRC_T3);
    end
  end

  // fourth flag register; bit 6 is stored only, software keeps it zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fl4_q <= RST_REG;
    end else if (ce_in) begin
      fl4_q <= ((wr && bus_in.addr == A_FL4) ? bus_in.wdata : fl4_q) & ~{3'h0, t_clr, 1'b0}
               | {evt_in.sleep, 1'b0, evt_in.port0, evt_in.timer, evt_in.dma};
    end
  end

  // fifth flag register, bits 7:5 not stored
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fl5_q <= RST_REG[4:0];
    end else if (ce_in) begin
      fl5_q <= ((wr && bus_in.addr == A_FL5) ? bus_in.wdata[4:0] : fl5_q)
               | {evt_in.wdt, evt_in.port1, evt_in.utx1, evt_in.utx0, evt_in.port2};
    end
  end

  // priority bits and source enables
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pri_hi_q <= RST_REG[5:0];
      pri_lo_q <= RST_REG[5:0];
      en_q     <= '0;
    end else if (ce_in && wr) begin
      if (bus_in.addr == A_PRI_HI) pri_hi_q <= bus_in.wdata[5:0];
      if (bus_in.addr == A_PRI_LO) pri_lo_q <= bus_in.wdata[5:0];
      if (bus_in.addr == A_EN_LO)  en_q[7:0] <= bus_in.wdata;
      if (bus_in.addr == A_EN_HI)  en_q[N_SRC-1:8] <= bus_in.wdata[N_SRC-9:0];
    end
  end

  // per-source pending view in polling order
  always_comb begin
    pend           = '0;
    pend[SRC_RADIO] = |radio_q;
    pend[SRC_DMA]  = fl4_q[B_DMA];
    pend[SRC_T1]   = fl4_q[B_T1];
    pend[SRC_T2]   = fl4_q[B_T1+1];
    pend[SRC_T3]   = fl4_q[B_T1+2];
    pend[SRC_AES]  = |aes_q;
    pend[SRC_T4]   = fl4_q[B_T4];
    pend[SRC_ST]   = fl4_q[B_ST];
    pend[SRC_P0]   = fl4_q[B_P0];
    pend[SRC_P2]   = fl5_q[B_P2];
    pend[SRC_UTX0] = fl5_q[B_UTX0];
    pend[SRC_UTX1] = fl5_q[B_UTX1];
    pend[SRC_P1]   = fl5_q[B_P1];
    pend[SRC_WDT]  = fl5_q[B_WDT];
  end

  // a flag only requests service while its source is enabled
  assign req = pend & en_q;

  // level of each source from its group's two bits
  generate
    for (genvar i = 0; i < N_SRC; i++) begin : g_lvl
      assign lvl[i*LVL_W +: LVL_W] = {pri_hi_q[GRP_OF[i]], pri_lo_q[GRP_OF[i]]};
    end
  endgenerate

  ifp_prio_arb #(
    .N  (N_SRC),
    .LW (LVL_W),
    .SW (SRC_W)
  ) u_arb (
    .req_in  (req),
    .lvl_in  (lvl),
    .vld_out (arb_vld),
    .src_out (arb_src),
    .lvl_out (arb_lvl)
  );

  // highest level now in service
  always_comb begin
    svc_any = |insvc_q;
    svc_lvl = '0;
    for (int l = 0; l < 4; l++) begin
      if (insvc_q[l]) svc_lvl = LVL_W'(l);
    end
  end

  // present a request only if it beats the running service
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_out     <= 1'b0;
      req_src_out <= '0;
      req_lvl_out <= '0;
    end else if (ce_in) begin
      req_out     <= arb_vld && !vec_ack_in && (!svc_any || arb_lvl > svc_lvl);
      req_src_out <= arb_src;
      req_lvl_out <= arb_lvl;
    end
  end

  // in-service levels: vector pushes, return pops the highest
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      insvc_q <= '0;
    end else if (ce_in) begin
      if (vec_ack_in) begin
        insvc_q[req_lvl_out] <= 1'b1;
      end else if (reti_in && svc_any) begin
        insvc_q[svc_lvl] <= 1'b0;
      end
    end
  end

  // block events: vector taken, nested vector, return
  assign evt_set = {reti_in && svc_any, vec_ack_in && svc_any, vec_ack_in};
  assign evt_clr = (wr && bus_in.addr == A_STAT) ? bus_in.wdata[N_EVT-1:0] : '0;

  ifp_evt_status #(
    .W (N_EVT)
  ) u_stat (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (evt_set),
    .clr_in     (evt_clr),
    .mask_wr_in (wr && bus_in.addr == A_MASK),
    .mask_in    (bus_in.wdata[N_EVT-1:0]),
    .stat_out   (stat),
    .mask_out   (mask),
    .irq_out    (irq_out)
  );

  // read data one cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (ce_in) begin
      rdata_out <= '0;
      if (bus_in.rd) begin
        unique case (bus_in.addr)
          A_AES:    rdata_out <= {6'h00, aes_q};
          A_RADIO:  rdata_out <= {6'h00, radio_q};
          A_PRI_HI: rdata_out <= {2'h0, pri_hi_q};
          A_PRI_LO: rdata_out <= {2'h0, pri_lo_q};
          A_FL4:    rdata_out <= fl4_q;
          A_FL5:    rdata_out <= {3'h0, fl5_q};
          A_EN_LO:  rdata_out <= en_q[7:0];
          A_EN_HI:  rdata_out <= {2'h0, en_q[N_SRC-1:8]};
          A_STAT:   rdata_out <= {5'h00, stat};
          A_MASK:   rdata_out <= {5'h00, mask};
          A_INSVC:  rdata_out <= {4'h0, insvc_q};
          default:  rdata_out <= '0;
        endcase
      end
    end
  end

  chk_aes_both_set:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && evt_in.aes) |=> (aes_q == 2'h3))
    else $error("aes event did not set both flags");

  chk_radio_both_set:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && evt_in.radio) |=> (radio_q == 2'h3))
    else $error("radio event did not set both flags");

  chk_aes_sw_set:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && wr && bus_in.addr == A_AES && bus_in.wdata[0]) |=> aes_q[0])
    else $error("software set of aes flag lost");

  chk_timer_vec_clear:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && vec_ack_in && req_src_out == SRC_T1 && !evt_in.timer[0] && !wr) |=> !fl4_q[B_T1])
    else $error("timer 1 flag not cleared on vector");

  chk_no_equal_nest:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && svc_any && !vec_ack_in && arb_lvl <= svc_lvl) |=> !req_out)
    else $error("request presented at or below the running level");

  chk_poll_first:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && !svc_any && !vec_ack_in && req[SRC_RADIO] && pri_hi_q[0] && pri_lo_q[0])
        |=> (req_out && req_src_out == SRC_RADIO && req_lvl_out == 2'h3))
    else $error("top-level radio request did not win the poll");

  chk_hi_unused_zero:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && bus_in.rd && bus_in.addr == A_PRI_HI) |=> (rdata_out[7:6] == 2'h0))
    else $error("unused priority bits read nonzero");

  chk_flag_no_enable:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && evt_in.dma && !en_q[SRC_DMA]) |=> fl4_q[B_DMA])
    else $error("disabled dma event did not set its flag");

  chk_t3_vec_clear:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && vec_ack_in && req_src_out == SRC_T3 && !evt_in.timer[2] && !wr) |=> !fl4_q[B_T1+2])
    else $error("timer 3 flag not cleared on vector");

  chk_vec_marks_level:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && vec_ack_in && req_lvl_out == 2'h1) |=> insvc_q[1])
    else $error("vectored level not marked in service");

  chk_sleep_flag_set:
    assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && evt_in.sleep) |=> fl4_q[B_ST])
    else $error("sleep timer event did not set its flag");
endmodule

/* File: tb/ifp_cpu_model.sv */
// Purpose: cpu core stand-in that vectors to requests and returns from them
// Assumes: requests come from the core under test as a registered level
// Notes:   ack latency is programmable so prompt and slow cpus are both seen
`timescale 1ns/1ns
module ifp_cpu_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       auto_in,
  input  wire logic [3:0] lat_in,
  input  wire logic       reti_go_in,
  input  wire logic       req_in,
  input  wire logic [3:0] src_in,
  input  wire logic [1:0] lvl_in,
  output logic            vec_ack_out,
  output logic            reti_out,
  output logic [3:0]      src_out,
  output logic [1:0]      lvl_out,
  output logic [7:0]      n_ack_out
);
  logic [3:0] wait_q;
  logic [2:0] depth_q;

  // ack only while a request stands, and never twice for one request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vec_ack_out <= 1'b0;
      wait_q      <= 4'h0;
      n_ack_out   <= 8'h00;
      src_out     <= 4'h0;
      lvl_out     <= 2'h0;
    end else begin
      vec_ack_out <= auto_in && req_in && !vec_ack_out && wait_q >= lat_in;
      wait_q      <= (auto_in && req_in && !vec_ack_out) ? wait_q + 4'h1 : 4'h0;
      if (vec_ack_out) begin
        src_out   <= src_in; // what the core sees at the taking edge
        lvl_out   <= lvl_in;
        n_ack_out <= n_ack_out + 8'h01;
      end
    end
  end

  // a return is only issued while some service is open
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reti_out <= 1'b0;
      depth_q  <= 3'h0;
    end else begin
      reti_out <= reti_go_in && depth_q != 3'h0;
      depth_q  <= depth_q + 3'(vec_ack_out) - 3'(reti_out);
    end
  end
endmodule

/* File: tb/ifp_core_tb.sv */
// Purpose: self-checking bench for the interrupt flag and priority core
// Assumes: bench plays software on the register port, model plays the cpu
// Notes:   directed stimulus only
`timescale 1ns/1ns
module ifp_core_tb;
  import ifp_pkg::*;
  logic       clk_in  = 1'b0;
  logic       rst_in  = 1'b1;
  logic       ce_in   = 1'b1;
  logic       auto    = 1'b0;
  logic       reti_go = 1'b0;
  logic [3:0] lat     = 4'h3;
  logic       vec_ack, reti, req, irq;
  logic [3:0] src, m_src;
  logic [1:0] lvl, m_lvl, lv;
  logic [7:0] rdata, n_ack, rv;
  ifp_bus_s   bus     = '0;
  ifp_evt_s   evt     = '0;
  int         n_fail  = 0;
  int         tests_run = 0;
  int         cyc     = 0;
  localparam logic [7:0] RADR [11] = '{A_AES, A_RADIO, A_PRI_LO, A_PRI_HI, A_FL4, A_FL5,
                                      A_EN_LO, A_EN_HI, A_STAT, A_MASK, A_INSVC};
  localparam logic [7:0] EV_A [14] = '{A_FL5, A_FL5, A_FL5, A_FL5, A_FL5, A_FL4, A_FL4,
                                      A_FL4, A_FL4, A_FL4, A_FL4, A_FL4, A_RADIO, A_AES};
  localparam logic [7:0] EV_D [14] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h01, 8'h20,
                                      8'h80, 8'h02, 8'h04, 8'h08, 8'h10, 8'h03, 8'h03};
  localparam logic [7:0] WIN [6]   = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07};

  ifp_core dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .bus_in(bus), .rdata_out(rdata),
    .evt_in(evt), .vec_ack_in(vec_ack), .reti_in(reti), .req_out(req), .req_src_out(src),
    .req_lvl_out(lvl), .irq_out(irq));
  ifp_cpu_model cpu (.clk_in(clk_in), .rst_in(rst_in), .auto_in(auto), .lat_in(lat),
    .reti_go_in(reti_go), .req_in(req), .src_in(src), .lvl_in(lvl), .vec_ack_out(vec_ack),
    .reti_out(reti), .src_out(m_src), .lvl_out(m_lvl), .n_ack_out(n_ack));

  // 20 MHz clock
  always #25 clk_in = ~clk_in;

  // a hang counts as a mismatch
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(string nm, logic e, logic g);
    chk_byte(nm, {7'h00, e}, {7'h00, g});
  endtask

  // one-cycle strobes, released at the next edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus <= '0;
    #1;
    d = rdata;
  endtask

  task automatic rchk(string nm, logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk_byte(nm, e, d);
  endtask

  task automatic ev(int b);
    @(posedge clk_in);
    evt <= ifp_evt_s'(14'h0001 << b);
    @(posedge clk_in);
    evt <= '0;
  endtask

  // request is registered one cycle behind the flag
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  task automatic wait_ack(logic [7:0] n);
    for (int i = 0; i < 40 && n_ack !== n; i++) @(posedge clk_in);
    #1;
    chk_byte("ack count", n, n_ack);
  endtask

  task automatic do_reti();
    @(posedge clk_in);
    reti_go <= 1'b1;
    @(posedge clk_in);
    reti_go <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    // reset values, unused bits, unmapped place and frozen clock enable
    foreach (RADR[i]) rchk("reset value", RADR[i], 8'h00);
    chk_bit("req after reset", 1'b0, req);
    wr(8'h01, 8'hff);
    rchk("unmapped", 8'h01, 8'h00);
    wr(A_PRI_HI, 8'hff);
    rchk("high prio unused", A_PRI_HI, 8'h3f);
    wr(A_PRI_HI, 8'h00);
    ce_in <= 1'b0;
    wr(A_AES, 8'h01);
    ce_in <= 1'b1;
    rchk("write with ce low", A_AES, 8'h00);
    // every event lands on its own flag, with all sources disabled
    for (int b = 0; b < N_SRC; b++) begin
      ev(b);
      rchk("event flag", EV_A[b], EV_D[b]);
      chk_bit("no request when disabled", 1'b0, req);
      wr(EV_A[b], 8'h00);
    end
    // all pending by software, ties at level zero go by polling order
    wr(A_EN_LO, 8'hff);
    wr(A_EN_HI, 8'h3f);
    wr(A_AES, 8'hfd);
    rchk("aes unused bits", A_AES, 8'h01);
    wr(A_RADIO, 8'h02);
    wr(A_FL4, 8'hbf);
    wr(A_FL5, 8'hff);
    rchk("fifth unused bits", A_FL5, 8'h1f);
    settle();
    chk_bit("request", 1'b1, req);
    chk_byte("tie winner", 8'h00, {4'h0, src});
    wr(A_RADIO, 8'h00);
    settle();
    chk_byte("tie winner", 8'h01, {4'h0, src});
    // raise one group at a time through all nonzero levels
    for (int g = 0; g < N_GRP; g++) begin
      lv = 2'((g % 3) + 1);
      wr(A_PRI_HI, 8'(lv[1]) << g);
      wr(A_PRI_LO, 8'(lv[0]) << g);
      settle();
      chk_byte("group winner", WIN[g], {4'h0, src});
      chk_byte("group level", {6'h00, lv}, {6'h00, lvl});
    end
    // group zero at the top level lets a software-set radio flag win outright
    wr(A_PRI_HI, 8'h01);
    wr(A_PRI_LO, 8'h01);
    wr(A_RADIO, 8'h01);
    settle();
    chk_byte("radio winner", 8'h00, {4'h0, src});
    chk_byte("radio level", 8'h03, {6'h00, lvl});
    foreach (RADR[i]) if (i < 6) wr(RADR[i], 8'h00);
    settle();
    chk_bit("request cleared", 1'b0, req);
    // vector to timer 1, then interrupt status raise, mask and clear
    auto <= 1'b1;
    ev(8);
    wait_ack(8'h01);
    chk_byte("vectored source", 8'h02, {4'h0, m_src});
    rchk("timer flag cleared", A_FL4, 8'h00);
    rchk("in service", A_INSVC, 8'h01);
    rchk("status vector", A_STAT, 8'h01);
    chk_bit("masked irq", 1'b0, irq);
    wr(A_MASK, 8'h01);
    #1;
    chk_bit("irq raised", 1'b1, irq);
    wr(A_STAT, 8'h01);
    #1;
    chk_bit("irq cleared", 1'b0, irq);
    // equal level waits, strictly higher level nests
    ev(9);
    repeat (10) @(posedge clk_in);
    chk_byte("equal level held", 8'h01, n_ack);
    rchk("timer 2 pending", A_FL4, 8'h04);
    wr(A_PRI_LO, 8'h04);
    wait_ack(8'h02);
    chk_byte("nested source", 8'h03, {4'h0, m_src});
    chk_byte("nested level", 8'h01, {6'h00, m_lvl});
    rchk("in service nested", A_INSVC, 8'h03);
    rd(A_STAT, rv);
    chk_byte("nested status", 8'h02, rv & 8'h02);
    do_reti();
    rchk("after return", A_INSVC, 8'h01);
    do_reti();
    rchk("all returned", A_INSVC, 8'h00);
    rd(A_STAT, rv);
    chk_byte("return status", 8'h04, rv & 8'h04);
    // prompt cpu on timer 3
    lat <= 4'h0;
    ev(10);
    wait_ack(8'h03);
    chk_byte("prompt source", 8'h04, {4'h0, m_src});
    rchk("timer 3 cleared", A_FL4, 8'h00);
    do_reti();
    end_sim();
  end
endmodule
